// File: shared/etd_pkg.sv
// Constants shared by the transmit descriptor DMA engine and its pointer module.
// Contract
// [R1] Buffers of zero to 2047 bytes are accepted; empty buffers are legal.
// [R2] Software builds no frame from more than 128 buffers.
// [R3] A descriptor is two words: buffer byte address, then control and status.
// [R4] With automatic checksum, frames are padded to reach 64 bytes on the wire.
// [R5] Buffer length sits in control bits 10:0; bit 15 marks a frame's last buffer.
// [R6] Control bit 16 in the last buffer suppresses the appended checksum.
// [R7] Bit 31 is ownership: zero before fetch, set in first buffer after success.
// [R8] After a frame, control, ownership and status go back to the first descriptor.
// [R9] Status bit 29 retry limit, bit 28 underrun, bit 27 buffers exhausted.
// [R10] Bit 30 wraps the ring from any buffer; after 1024 descriptors it rolls over.
// [R11] Software never writes the queue pointer while transmission runs.
// [R12] A queue pointer write restarts the descriptor pointer at the new ring.
// [R13] Transmit disable returns the descriptor pointer to the ring start.
// [R14] Start sets the run flag and begins the ring; repeated starts are harmless.
// [R15] Run flag clears on disable, owned descriptor, pointer write, halt, or error.
// [R16] A halt takes effect only after the frame in progress completes.
// [R17] A collision on a multi-buffer frame restarts it from its first buffer.
// [R18] An owned descriptor mid-frame is an error: stop, error line, corrupt checksum.
// [R19] After an error stop the pointer returns to the ring start; software rebuilds.
// [R20] An owned descriptor at frame start stops but keeps the pointer for resume.
// [R21] A received pause with pause handling enabled holds off new frame starts.
// [R22] A data underrun appends a corrupt checksum and raises the error line.
// [R23] Without wrap, the next descriptor is the two-word entry that follows.
package etd_pkg;
   // -----------------------------------------------------------------
   // Descriptor layout.
   // -----------------------------------------------------------------
   localparam int DESC_SHIFT = 3;
   localparam logic [31:0] CTRL_WORD_OFS = 32'h0000_0004;
   localparam int LEN_MSB = 10;
   localparam int LEN_W = 11;
   localparam int BIT_LAST = 15;
   localparam int BIT_NOCRC = 16;
   localparam int BIT_EXHAUST = 27;
   localparam int BIT_UNDERRUN = 28;
   localparam int BIT_RETRY = 29;
   localparam int BIT_WRAP = 30;
   localparam int BIT_USED = 31;
   // -----------------------------------------------------------------
   // Ring, frame and beat sizes.
   // -----------------------------------------------------------------
   localparam int RING_IDX_W = 10;
   localparam int FRAME_CNT_W = 18;
   localparam logic [17:0] MIN_FRAME_NO_FCS = 18'h0003c;
   localparam logic [2:0] WORD_BYTES = 3'h4;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

   // Engine states.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_RD_ADDR = 4'h1,
      ST_RD_CTRL = 4'h2,
      ST_DATA_RD = 4'h3,
      ST_DATA_TX = 4'h4,
      ST_FILL = 4'h5,
      ST_WAIT_DONE = 4'h6,
      ST_ABORT = 4'h7,
      ST_WB = 4'h8
   } etd_state_e;
endpackage : etd_pkg

// File: shared/etd_ptr_if.sv
// Command and address carrier between the engine and the descriptor pointer.
interface etd_ptr_if;
   logic load_base;
   logic [31:0] base_val;
   logic to_start;
   logic to_first;
   logic mark_first;
   logic advance;
   logic wrap;
   logic [31:0] cur_addr;
   logic [31:0] first_addr;

   modport eng (
      output load_base,
      output base_val,
      output to_start,
      output to_first,
      output mark_first,
      output advance,
      output wrap,
      input cur_addr,
      input first_addr
   );
   modport ptr (
      input load_base,
      input base_val,
      input to_start,
      input to_first,
      input mark_first,
      input advance,
      input wrap,
      output cur_addr,
      output first_addr
   );
endinterface : etd_ptr_if

// File: rtl/etd_desc_ptr.sv
// Descriptor ring pointer: ring base, current entry and first entry of the frame.
module etd_desc_ptr (
   input wire logic core_clk,
   input wire logic rstn,
   etd_ptr_if.ptr p
);
   logic [31:0] base_ff;
   logic [31:0] nxt_base;
   logic [etd_pkg::RING_IDX_W-1:0] idx_ff;
   logic [etd_pkg::RING_IDX_W-1:0] nxt_idx;
   logic [etd_pkg::RING_IDX_W-1:0] first_ff;
   logic [etd_pkg::RING_IDX_W-1:0] nxt_first;

   // -----------------------------------------------------------------
   // Pointer update.
   // -----------------------------------------------------------------
   // Commands are prioritised so a ring reload always beats frame-local moves.
   always_comb begin
      nxt_base = base_ff;
      nxt_idx = idx_ff;
      nxt_first = first_ff;
      if (p.load_base) begin
         nxt_base = p.base_val; // R12
         nxt_idx = '0;
         nxt_first = '0;
      end else if (p.to_start) begin
         nxt_idx = '0; // R13 R19
         nxt_first = '0;
      end else if (p.to_first) begin
         nxt_idx = first_ff; // R17
      end else begin
         if (p.mark_first) begin
            nxt_first = idx_ff;
         end
         if (p.advance) begin
            // The counter width makes entry 1024 roll back to entry 0.
            nxt_idx = p.wrap ? '0 : idx_ff + 1'b1; // R10 R23
         end
      end
   end

   // Registers of the pointer.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         base_ff <= etd_pkg::ADDR_RESET;
         idx_ff <= '0;
         first_ff <= '0;
      end else begin
         base_ff <= nxt_base;
         idx_ff <= nxt_idx;
         first_ff <= nxt_first;
      end
   end

   // Entry addresses: two words per descriptor.
   assign p.cur_addr = base_ff + (32'(idx_ff) << etd_pkg::DESC_SHIFT); // R3 R23
   assign p.first_addr = base_ff + (32'(first_ff) << etd_pkg::DESC_SHIFT);
endmodule : etd_desc_ptr

// File: rtl/etd_tx_dma.sv
// Transmit descriptor DMA engine: ring walk, data fetch, padding and status write-back.
module etd_tx_dma (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tx_enable,
   input wire logic tx_start_wr,
   input wire logic tx_halt_wr,
   input wire logic qptr_wr,
   input wire logic [31:0] qptr_wdata,
   input wire logic pause_en,
   input wire logic pause_hold,
   output logic tx_go_ff,
   output logic [31:0] qptr_ff,
   output logic busy_ff,
   output logic used_stop_ff,
   output logic err_stop_ff,
   output logic frame_ok_ff,
   output logic mem_req_ff,
   output logic mem_we_ff,
   output logic [31:0] mem_addr_ff,
   output logic [31:0] mem_wdata_ff,
   input wire logic mem_ack,
   input wire logic mem_err,
   input wire logic [31:0] mem_rdata,
   output logic tx_valid_ff,
   output logic [31:0] tx_data_ff,
   output logic [1:0] tx_lane_ff,
   output logic [2:0] tx_bytes_ff,
   output logic tx_last_ff,
   output logic tx_nocrc_ff,
   output logic tx_bad_fcs_ff,
   output logic tx_er_ff,
   input wire logic tx_ready,
   input wire logic tx_done,
   input wire logic tx_collision,
   input wire logic tx_retry_err
);
   etd_ptr_if pif ();

   etd_desc_ptr u_ptr (
      .core_clk(core_clk),
      .rstn(rstn),
      .p(pif.ptr)
   );

   etd_pkg::etd_state_e state_ff, nxt_state;
   logic nxt_go, nxt_busy, nxt_used_stop, nxt_err_stop, nxt_frame_ok;
   logic nxt_req, nxt_we, nxt_valid, nxt_last, nxt_nocrc, nxt_bad_fcs, nxt_er;
   logic [31:0] nxt_addr, nxt_wdata, nxt_data, nxt_qptr;
   logic [1:0] nxt_lane;
   logic [2:0] nxt_bytes;
   logic [31:0] buf_addr_ff, nxt_buf_addr;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] first_ctrl_ff, nxt_first_ctrl;
   logic [etd_pkg::LEN_W-1:0] rem_ff, nxt_rem;
   logic [etd_pkg::FRAME_CNT_W-1:0] fbytes_ff, nxt_fbytes;
   logic first_buf_ff, nxt_first_buf;
   logic wrap_seen_ff, nxt_wrap_seen;
   logic err_ff, nxt_err;
   logic [2:0] stat_ff, nxt_stat;
   logic [2:0] beat_n;
   logic [2:0] lane_room;
   logic [2:0] pad_n;
   logic [etd_pkg::FRAME_CNT_W-1:0] pad_left;
   logic [etd_pkg::FRAME_CNT_W-1:0] fb_after;
   logic acked;

   // Returns the smaller of a beat's room and the bytes still wanted.
   function automatic logic [2:0] beat_size(input logic [2:0] room,
                                            input logic [etd_pkg::FRAME_CNT_W-1:0] want);
      beat_size = (want < etd_pkg::FRAME_CNT_W'(room)) ? want[2:0] : room;
   endfunction : beat_size

   // -----------------------------------------------------------------
   // Beat sizing.
   // -----------------------------------------------------------------
   // A beat never crosses a word, so an unaligned buffer starts mid-word.
   always_comb begin
      lane_room = etd_pkg::WORD_BYTES - {1'b0, buf_addr_ff[1:0]};
      beat_n = beat_size(lane_room, etd_pkg::FRAME_CNT_W'(rem_ff)); // R1
      fb_after = fbytes_ff + etd_pkg::FRAME_CNT_W'(beat_n);
      pad_left = (fbytes_ff < etd_pkg::MIN_FRAME_NO_FCS) ?
                 etd_pkg::MIN_FRAME_NO_FCS - fbytes_ff : '0;
      pad_n = beat_size(etd_pkg::WORD_BYTES, pad_left);
      acked = mem_req_ff && mem_ack;
   end

   // -----------------------------------------------------------------
   // Engine next state.
   // -----------------------------------------------------------------
   // Memory requests are issued one cycle after a state is entered, so the
   // pointer module has already settled on the entry being addressed.
   always_comb begin
      nxt_state = state_ff;
      nxt_go = tx_go_ff;
      nxt_used_stop = 1'b0;
      nxt_err_stop = 1'b0;
      nxt_frame_ok = 1'b0;
      nxt_req = mem_req_ff;
      nxt_we = mem_we_ff;
      nxt_addr = mem_addr_ff;
      nxt_wdata = mem_wdata_ff;
      nxt_valid = tx_valid_ff;
      nxt_data = tx_data_ff;
      nxt_lane = tx_lane_ff;
      nxt_bytes = tx_bytes_ff;
      nxt_last = tx_last_ff;
      nxt_nocrc = tx_nocrc_ff;
      nxt_bad_fcs = tx_bad_fcs_ff;
      nxt_er = 1'b0;
      nxt_buf_addr = buf_addr_ff;
      nxt_ctrl = ctrl_ff;
      nxt_first_ctrl = first_ctrl_ff;
      nxt_rem = rem_ff;
      nxt_fbytes = fbytes_ff;
      nxt_first_buf = first_buf_ff;
      nxt_wrap_seen = wrap_seen_ff;
      nxt_err = err_ff;
      nxt_stat = stat_ff;
      pif.load_base = 1'b0;
      pif.base_val = qptr_wdata;
      pif.to_start = 1'b0;
      pif.to_first = 1'b0;
      pif.mark_first = 1'b0;
      pif.advance = 1'b0;
      pif.wrap = ctrl_ff[etd_pkg::BIT_WRAP];
      if (acked) begin
         nxt_req = 1'b0;
      end
      if (tx_start_wr) begin
         nxt_go = 1'b1; // R14
      end
      if (tx_halt_wr) begin
         nxt_go = 1'b0; // R15 R16
      end
      case (state_ff)
         etd_pkg::ST_IDLE: begin
            if (tx_go_ff && !(pause_en && pause_hold)) begin // R21
               pif.mark_first = 1'b1;
               nxt_first_buf = 1'b1;
               nxt_fbytes = '0;
               nxt_err = 1'b0;
               nxt_stat = '0;
               nxt_wrap_seen = 1'b0;
               nxt_state = etd_pkg::ST_RD_ADDR;
            end
         end
         etd_pkg::ST_RD_ADDR: begin
            if (!mem_req_ff) begin
               nxt_req = 1'b1;
               nxt_we = 1'b0;
               nxt_addr = pif.cur_addr; // R3
            end else if (acked) begin
               nxt_buf_addr = mem_rdata;
               nxt_state = mem_err ? etd_pkg::ST_ABORT : etd_pkg::ST_RD_CTRL;
            end
         end
         etd_pkg::ST_RD_CTRL: begin
            if (!mem_req_ff) begin
               nxt_req = 1'b1;
               nxt_addr = pif.cur_addr + etd_pkg::CTRL_WORD_OFS;
            end else if (acked) begin
               nxt_ctrl = mem_rdata;
               nxt_rem = mem_rdata[etd_pkg::LEN_MSB:0]; // R5
               nxt_wrap_seen = wrap_seen_ff | mem_rdata[etd_pkg::BIT_WRAP];
               if (first_buf_ff) begin
                  nxt_first_ctrl = mem_rdata;
               end
               if (mem_err) begin
                  nxt_state = etd_pkg::ST_ABORT;
               end else if (mem_rdata[etd_pkg::BIT_USED] && first_buf_ff) begin
                  // Pointer stays on this entry so a later start resumes here.
                  nxt_go = 1'b0; // R7 R15 R20
                  nxt_used_stop = 1'b1;
                  nxt_state = etd_pkg::ST_IDLE;
               end else if (mem_rdata[etd_pkg::BIT_USED]) begin
                  nxt_stat = 3'h3; // R9 R18
                  nxt_state = etd_pkg::ST_ABORT;
               end else if (mem_rdata[etd_pkg::LEN_MSB:0] != '0) begin
                  nxt_state = etd_pkg::ST_DATA_RD;
               end else if (mem_rdata[etd_pkg::BIT_LAST]) begin
                  nxt_state = etd_pkg::ST_FILL; // R1
               end else begin
                  pif.advance = 1'b1;
                  pif.wrap = mem_rdata[etd_pkg::BIT_WRAP];
                  nxt_first_buf = 1'b0;
                  nxt_state = etd_pkg::ST_RD_ADDR;
               end
            end
         end
         etd_pkg::ST_DATA_RD: begin
            if (!mem_req_ff) begin
               nxt_req = 1'b1;
               nxt_addr = {buf_addr_ff[31:2], 2'b00};
            end else if (acked) begin
               if (mem_err) begin
                  nxt_stat = 3'h1; // R9 R22
                  nxt_state = etd_pkg::ST_ABORT;
               end else begin
                  nxt_valid = 1'b1;
                  nxt_data = mem_rdata;
                  nxt_lane = buf_addr_ff[1:0];
                  nxt_bytes = beat_n;
                  nxt_nocrc = ctrl_ff[etd_pkg::BIT_NOCRC]; // R6
                  nxt_bad_fcs = 1'b0;
                  nxt_last = ctrl_ff[etd_pkg::BIT_LAST] &&
                             (rem_ff == etd_pkg::LEN_W'(beat_n)) &&
                             (ctrl_ff[etd_pkg::BIT_NOCRC] ||
                              fb_after >= etd_pkg::MIN_FRAME_NO_FCS);
                  nxt_buf_addr = buf_addr_ff + 32'(beat_n);
                  nxt_rem = rem_ff - etd_pkg::LEN_W'(beat_n);
                  nxt_fbytes = fb_after;
                  nxt_state = etd_pkg::ST_DATA_TX;
               end
            end
         end
         etd_pkg::ST_DATA_TX: begin
            if (tx_ready) begin
               nxt_valid = 1'b0;
               if (rem_ff != '0) begin
                  nxt_state = etd_pkg::ST_DATA_RD;
               end else if (tx_last_ff) begin
                  nxt_state = etd_pkg::ST_WAIT_DONE;
               end else if (ctrl_ff[etd_pkg::BIT_LAST]) begin
                  nxt_state = etd_pkg::ST_FILL; // R4
               end else begin
                  pif.advance = 1'b1; // R23
                  nxt_first_buf = 1'b0;
                  nxt_state = etd_pkg::ST_RD_ADDR;
               end
            end
         end
         etd_pkg::ST_FILL: begin
            // Zero bytes up to the minimum length; a suppressed checksum skips it.
            if (!tx_valid_ff) begin
               nxt_valid = 1'b1;
               nxt_data = '0;
               nxt_lane = '0;
               nxt_bytes = ctrl_ff[etd_pkg::BIT_NOCRC] ? 3'h0 : pad_n; // R4 R6
               nxt_nocrc = ctrl_ff[etd_pkg::BIT_NOCRC];
               nxt_bad_fcs = 1'b0;
               nxt_last = ctrl_ff[etd_pkg::BIT_NOCRC] ||
                          (pad_left == etd_pkg::FRAME_CNT_W'(pad_n));
               nxt_fbytes = ctrl_ff[etd_pkg::BIT_NOCRC] ? fbytes_ff :
                            fbytes_ff + etd_pkg::FRAME_CNT_W'(pad_n);
            end else if (tx_ready) begin
               nxt_valid = 1'b0;
               if (tx_last_ff) begin
                  nxt_state = etd_pkg::ST_WAIT_DONE;
               end
            end
         end
         etd_pkg::ST_WAIT_DONE: begin
            if (tx_retry_err) begin
               nxt_stat = 3'h4; // R9
               nxt_err = 1'b1;
               nxt_state = etd_pkg::ST_WB;
            end else if (tx_collision) begin
               pif.to_first = 1'b1; // R17
               nxt_first_buf = 1'b1;
               nxt_fbytes = '0;
               nxt_state = etd_pkg::ST_RD_ADDR;
            end else if (tx_done) begin
               nxt_state = etd_pkg::ST_WB;
            end
         end
         etd_pkg::ST_ABORT: begin
            // Closing beat that makes the transmitter send a corrupt checksum.
            if (!tx_valid_ff) begin
               nxt_valid = 1'b1;
               nxt_bytes = '0;
               nxt_last = 1'b1;
               nxt_bad_fcs = 1'b1; // R18 R22
               nxt_er = 1'b1;
               nxt_err = 1'b1;
               if (stat_ff == '0) begin
                  nxt_stat = 3'h1;
               end
            end else if (tx_ready) begin
               nxt_valid = 1'b0;
               nxt_bad_fcs = 1'b0;
               nxt_state = etd_pkg::ST_WB;
            end else begin
               nxt_er = 1'b1; // R18 R22
            end
         end
         etd_pkg::ST_WB: begin
            if (!mem_req_ff) begin
               nxt_req = 1'b1;
               nxt_we = 1'b1;
               nxt_addr = pif.first_addr + etd_pkg::CTRL_WORD_OFS; // R8
               nxt_wdata = first_ctrl_ff;
               nxt_wdata[etd_pkg::BIT_USED] = !err_ff; // R7
               nxt_wdata[etd_pkg::BIT_UNDERRUN] = stat_ff[0]; // R9
               nxt_wdata[etd_pkg::BIT_EXHAUST] = stat_ff[1];
               nxt_wdata[etd_pkg::BIT_RETRY] = stat_ff[2];
            end else if (acked) begin
               nxt_we = 1'b0;
               if (err_ff) begin
                  pif.to_start = 1'b1; // R19
                  nxt_go = 1'b0; // R15
                  nxt_err_stop = 1'b1;
               end else begin
                  pif.advance = 1'b1;
                  pif.wrap = wrap_seen_ff; // R10
                  nxt_frame_ok = 1'b1;
               end
               nxt_state = etd_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = etd_pkg::ST_IDLE;
         end
      endcase
      // Disable cancels everything in flight; a new ring pointer only reloads the pointer and clears the run flag.
      if (!tx_enable) begin
         pif.to_start = 1'b1; // R13
         nxt_go = 1'b0; // R15
         nxt_state = etd_pkg::ST_IDLE;
         nxt_req = 1'b0;
         nxt_we = 1'b0;
         nxt_valid = 1'b0;
         nxt_bad_fcs = 1'b0;
         nxt_er = 1'b0;
      end
      if (qptr_wr) begin
         pif.load_base = 1'b1; // R12
         nxt_go = 1'b0; // R15
      end
      nxt_busy = (nxt_state != etd_pkg::ST_IDLE);
      nxt_qptr = pif.cur_addr;
   end

   // -----------------------------------------------------------------
   // Engine registers.
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_ff <= etd_pkg::ST_IDLE;
         tx_go_ff <= 1'b0;
         qptr_ff <= etd_pkg::ADDR_RESET;
         busy_ff <= 1'b0;
         used_stop_ff <= 1'b0;
         err_stop_ff <= 1'b0;
         frame_ok_ff <= 1'b0;
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= etd_pkg::ADDR_RESET;
         mem_wdata_ff <= '0;
         tx_valid_ff <= 1'b0;
         tx_data_ff <= '0;
         tx_lane_ff <= '0;
         tx_bytes_ff <= '0;
         tx_last_ff <= 1'b0;
         tx_nocrc_ff <= 1'b0;
         tx_bad_fcs_ff <= 1'b0;
         tx_er_ff <= 1'b0;
         buf_addr_ff <= etd_pkg::ADDR_RESET;
         ctrl_ff <= '0;
         first_ctrl_ff <= '0;
         rem_ff <= '0;
         fbytes_ff <= '0;
         first_buf_ff <= 1'b0;
         wrap_seen_ff <= 1'b0;
         err_ff <= 1'b0;
         stat_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         tx_go_ff <= nxt_go;
         qptr_ff <= nxt_qptr;
         busy_ff <= nxt_busy;
         used_stop_ff <= nxt_used_stop;
         err_stop_ff <= nxt_err_stop;
         frame_ok_ff <= nxt_frame_ok;
         mem_req_ff <= nxt_req;
         mem_we_ff <= nxt_we;
         mem_addr_ff <= nxt_addr;
         mem_wdata_ff <= nxt_wdata;
         tx_valid_ff <= nxt_valid;
         tx_data_ff <= nxt_data;
         tx_lane_ff <= nxt_lane;
         tx_bytes_ff <= nxt_bytes;
         tx_last_ff <= nxt_last;
         tx_nocrc_ff <= nxt_nocrc;
         tx_bad_fcs_ff <= nxt_bad_fcs;
         tx_er_ff <= nxt_er;
         buf_addr_ff <= nxt_buf_addr;
         ctrl_ff <= nxt_ctrl;
         first_ctrl_ff <= nxt_first_ctrl;
         rem_ff <= nxt_rem;
         fbytes_ff <= nxt_fbytes;
         first_buf_ff <= nxt_first_buf;
         wrap_seen_ff <= nxt_wrap_seen;
         err_ff <= nxt_err;
         stat_ff <= nxt_stat;
      end
   end
endmodule : etd_tx_dma

// File: test/etd_tx_dma_props.sv
// Port checks for the transmit DMA engine, bound to its top module.
module etd_tx_dma_props (
   input logic core_clk,
   input logic rstn,
   input logic tx_enable,
   input logic tx_start_wr,
   input logic tx_halt_wr,
   input logic qptr_wr,
   input logic [31:0] qptr_wdata,
   input logic tx_go_ff,
   input logic [31:0] qptr_ff,
   input logic busy_ff,
   input logic tx_valid_ff,
   input logic [2:0] tx_bytes_ff,
   input logic tx_last_ff,
   input logic tx_bad_fcs_ff,
   input logic tx_er_ff,
   input logic tx_ready
);
   // ----
   // All checks sample on the rising edge and stay quiet in reset.
   // ----
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_start; tx_enable && tx_start_wr && !tx_halt_wr && !qptr_wr |=> tx_go_ff; endproperty
   a_start: assert property (p_start) else $error("start lost");
   property p_halt; tx_halt_wr |=> !tx_go_ff; endproperty
   a_halt: assert property (p_halt) else $error("halt kept run flag");
   property p_qptr; qptr_wr |-> ##2 qptr_ff == $past(qptr_wdata, 2); endproperty
   a_qptr: assert property (p_qptr) else $error("pointer not at new ring");
   property p_dis; !tx_enable |=> !tx_go_ff; endproperty
   a_dis: assert property (p_dis) else $error("disable kept run flag");
   property p_idle; !tx_enable [*2] |=> !busy_ff; endproperty
   a_idle: assert property (p_idle) else $error("disabled engine busy");
   property p_er; tx_er_ff |-> tx_valid_ff && tx_bad_fcs_ff && tx_last_ff
      && tx_bytes_ff == 3'h0; endproperty
   a_er: assert property (p_er) else $error("error line off abort beat");
   property p_bad; tx_valid_ff && tx_bad_fcs_ff && !tx_ready |=> tx_er_ff; endproperty
   a_bad: assert property (p_bad) else $error("error line missing");
   property p_hold; tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_bytes_ff); endproperty
   a_hold: assert property (p_hold) else $error("beat dropped");
endmodule : etd_tx_dma_props
bind etd_tx_dma etd_tx_dma_props i_props (.*);

// File: test/etd_mem_model.sv
// Behavioural system memory answering descriptor reads, data reads and write-backs.
module etd_mem_model (
   input wire logic core_clk,
   input wire logic slow,
   input wire logic mem_req_ff,
   input wire logic mem_we_ff,
   input wire logic [31:0] mem_addr_ff,
   input wire logic [31:0] mem_wdata_ff,
   output logic mem_ack,
   output logic mem_err,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [1024];
   logic [31:0] last = 32'h0;
   int wt = 0;
   // The model never reports a bus error.
   assign mem_err = 1'b0;
   // Fill with a pattern so buffer reads never return unknowns.
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      for (int i = 0; i < 1024; i++) mem[i] = i;
   end
   // One access at a time, prompt or three cycles late; data is scrambled outside ack.
   always @(posedge core_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~last;
      if (mem_req_ff && !mem_ack) begin
         if (wt < (slow ? 3 : 0)) begin
            wt <= wt + 1;
         end else begin
            wt <= 0;
            mem_ack <= 1'b1;
            if (mem_we_ff) mem[mem_addr_ff[11:2]] <= mem_wdata_ff;
            else mem_rdata <= mem[mem_addr_ff[11:2]];
            if (!mem_we_ff) last <= mem[mem_addr_ff[11:2]];
         end
      end
   end
endmodule : etd_mem_model

// File: test/etd_tx_dma_tb_top.sv
// Self-checking bench for the transmit descriptor DMA engine.
module etd_tx_dma_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] BASE = 32'h0000_0100;
   typedef struct {logic [31:0] ctrl; int exp;} etd_row_s;
   etd_row_s rows [5] = '{'{32'h0001_8000, 0}, '{32'h0000_800a, 60}, '{32'h0001_8064, 100},
      '{32'h0000_87ff, 2047}, '{32'h4000_8004, 60}};
   logic core_clk = 0, rstn = 0, tx_enable = 0, tx_start_wr = 0, tx_halt_wr = 0, qptr_wr = 0;
   logic pause_en = 0, pause_hold = 0, tx_ready = 0, tx_done = 0, tx_retry_err = 0;
   logic tx_collision = 0, slow = 0, mode = 0, pend = 0, coll = 0;
   logic [31:0] qptr_wdata = BASE;
   logic tx_go_ff, busy_ff, used_stop_ff, err_stop_ff, frame_ok_ff, mem_req_ff, mem_we_ff;
   logic mem_ack, mem_err, tx_valid_ff, tx_last_ff, tx_nocrc_ff, tx_bad_fcs_ff, tx_er_ff;
   logic [31:0] qptr_ff, mem_addr_ff, mem_wdata_ff, mem_rdata, tx_data_ff;
   logic [1:0] tx_lane_ff;
   logic [2:0] tx_bytes_ff, ev;
   int n_errors = 0, checks_done = 0, nb = 0, nbad = 0;
   etd_tx_dma i_dut (.*);
   etd_mem_model i_mem (.*);
   initial forever #2 core_clk = ~core_clk;
   // Transmit side: stalls every other cycle, counts bytes, reports done or retry.
   always @(negedge core_clk) begin
      tx_done = pend && !mode;
      tx_retry_err = pend && mode;
      tx_collision = pend && coll;
      coll &= !pend;
      pend = 0;
      tx_ready = ~tx_ready;
      if (tx_valid_ff && tx_ready) begin
         nb += tx_bytes_ff;
         nbad += tx_bad_fcs_ff;
         pend = tx_last_ff && !tx_bad_fcs_ff;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic desc(input int i, input logic [31:0] c);
      i_mem.mem[(BASE >> 2) + 2 * i] = 32'h0000_0800;
      i_mem.mem[(BASE >> 2) + 2 * i + 1] = c;
   endtask : desc
   task automatic start();
      nb = 0;
      nbad = 0;
      @(negedge core_clk);
      tx_start_wr = 1;
      @(negedge core_clk);
      tx_start_wr = 0;
   endtask : start
   task automatic wait_ev();
      ev = 0;
      for (int k = 0; k < 6000 && ev == 0; k++) begin
         @(negedge core_clk);
         ev = {frame_ok_ff, err_stop_ff, used_stop_ff};
      end
      repeat (3) @(negedge core_clk);
   endtask : wait_ev
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // Watchdog well beyond the expected run length.
   initial begin
      #100000;
      n_errors++;
      wrap_up();
   end
   // Reset, ring set-up, table of single-buffer frames, then the awkward cases.
   initial begin
      repeat (2) @(negedge core_clk);
      chk({tx_go_ff, busy_ff, mem_req_ff, tx_valid_ff, tx_er_ff}, 0);
      chk(qptr_ff, 0);
      rstn = 1;
      tx_enable = 1;
      qptr_wr = 1;
      @(negedge core_clk);
      qptr_wr = 0;
      repeat (2) @(negedge core_clk);
      chk(qptr_ff, BASE);
      foreach (rows[i]) desc(i, rows[i].ctrl);
      foreach (rows[i]) begin
         slow = i[0];
         start();
         if (i == 3) begin
            repeat (40) @(negedge core_clk);
            tx_halt_wr = 1;
            @(negedge core_clk);
            tx_halt_wr = 0;
         end
         wait_ev();
         chk(ev, 3'h4);
         chk(nb, rows[i].exp);
         chk(i_mem.mem[(BASE >> 2) + 2 * i + 1], rows[i].ctrl | 32'h8000_0000);
         chk(qptr_ff, i == 4 ? BASE : BASE + 8 * (i + 1));
      end
      desc(0, 32'h8000_8004);
      start();
      wait_ev();
      chk(ev, 3'h1);
      chk({qptr_ff, tx_go_ff}, {BASE, 1'b0});
      desc(0, 32'h0000_0004);
      desc(1, 32'h0000_8004);
      coll = 1;
      pause_en = 1;
      pause_hold = 1;
      start();
      repeat (30) @(negedge core_clk);
      chk(nb, 0);
      pause_hold = 0;
      wait_ev();
      chk({ev, nb[7:0]}, {3'h4, 8'd120});
      tx_enable = 0;
      repeat (2) @(negedge core_clk);
      chk({qptr_ff, tx_go_ff}, {BASE, 1'b0});
      tx_enable = 1;
      desc(0, 32'h0000_0008);
      desc(1, 32'h8000_8008);
      start();
      wait_ev();
      chk({ev, nbad[3:0]}, {3'h2, 4'h1});
      chk(i_mem.mem[(BASE >> 2) + 1], 32'h1800_0008);
      chk(qptr_ff, BASE);
      desc(0, 32'h0000_8004);
      mode = 1;
      start();
      wait_ev();
      chk({ev, tx_go_ff}, {3'h2, 1'b0});
      chk(i_mem.mem[(BASE >> 2) + 1], 32'h2000_8004);
      wrap_up();
   end
endmodule : etd_tx_dma_tb_top
